// ===== rtl/cmbx_defs.vh
/*
  Shared constants of the mailbox receive-write block: mailbox word map,
  field positions inside the identifier and control words, the packed
  frame layout used in the receive FIFO, and reset values.
  Assumes it is included by bare name from every design file that needs it.
*/
// Operation
// R01 - identifier word holds control bits 13 and 14
// R02 - prior-cycle processor access copies into those bits
// R03 - defect hits only receive and auto-reply mailboxes
// R04 - mask-enable zero means exact identifier match only
// R05 - auto-answer bit set replies remote request, clear doesn't
// R06 - processor rewrites both bits after every reception
// R07 - corrected mode leaves bits 13, 14 untouched
`ifndef CMBX_DEFS_VH
`define CMBX_DEFS_VH

// mailbox word map (eight 16-bit words per mailbox)
`define CMBX_WSEL_W 3
`define CMBX_W_IDENT 3'h0
`define CMBX_W_CTRL 3'h1
`define CMBX_W_DATA0 3'h2
`define CMBX_DATA_WORDS 2'h3

// identifier word fields
`define CMBX_ID_MSB 10
`define CMBX_ID_W 11
`define CMBX_AME_BIT 13
`define CMBX_AAM_BIT 14
`define CMBX_CTL_HI 14
`define CMBX_CTL_LO 13

// control word fields
`define CMBX_DLC_MSB 3
`define CMBX_RTR_BIT 4
`define CMBX_CTRL_PAD 11'h000

// packed frame in the FIFO: {data, dlc, rtr, id}
`define CMBX_FRM_W 80
`define CMBX_FRM_ID_LO 0
`define CMBX_FRM_RTR 11
`define CMBX_FRM_DLC_LO 12
`define CMBX_FRM_DATA_LO 16

// reset values
`define CMBX_WORD_RST 16'h0000
`define CMBX_BITS2_RST 2'h0

`endif

// ===== rtl/cmbx_fifo.v
/*
  Synchronous FIFO with parameterised width and depth, valid/ready on
  both sides. Input ready is a flop so a top-level port can use it.
  Assumes one clock and an already synchronised active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cmbx_fifo #(
  parameter W = 80,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk, // system clock
  input wire i_rst_n, // synchronised reset, active low
  input wire i_valid, // write side valid
  output wire o_ready, // write side ready, from flop
  input wire [W-1:0] i_data, // write data
  output wire o_valid, // read side valid
  input wire i_ready, // read side ready
  output wire [W-1:0] o_data // read data, head of queue
);
  reg [W-1:0] mem_reg [0:DEPTH-1]; // storage
  reg [AW-1:0] wptr_reg; // write pointer
  reg [AW-1:0] rptr_reg; // read pointer
  reg [AW:0] count_reg; // fill level
  reg ready_reg; // not full
  reg [AW:0] count_next;
  wire push;
  wire pop;

  assign o_valid = (count_reg != {(AW+1){1'b0}});
  assign o_ready = ready_reg;
  assign o_data = mem_reg[rptr_reg];
  assign push = i_valid & ready_reg;
  assign pop = o_valid & i_ready;

  // fill level follows push and pop together
  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // pointers, level and ready; ready drops the cycle the last slot fills
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      ready_reg <= 1'b1;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == DEPTH - 1) ? {AW{1'b0}} : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == DEPTH - 1) ? {AW{1'b0}} : rptr_reg + 1'b1;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != DEPTH[AW:0]);
    end
  end

  // storage needs no reset, only written entries are ever read
  always @(posedge i_clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= i_data;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cmbx_mailbox.v
/*
  Mailbox RAM with the receive-write engine of a CAN controller.
  Received frames queue in a FIFO, are matched to a receive or
  auto-reply mailbox and written word by word; the mailbox identifier
  word carries accept_mask_enable and auto_answer_enable. A switch
  selects the legacy collision behaviour or the corrected write.
  Assumes the protocol engine and the processor run on i_mclk; only the
  reset comes from outside and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmbx_defs.vh"
module cmbx_mailbox #(
  parameter NUM_MBX = 6,
  parameter MW = 3,
  parameter AW = 6,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire i_mclk, // 200 MHz system clock
  input wire i_nrst, // async reset, active low
  input wire i_cpu_req, // processor access strobe
  input wire i_cpu_we, // 1 write, 0 read
  input wire [AW-1:0] i_cpu_addr, // word address {mailbox, word}
  input wire [15:0] i_cpu_wdata, // write data
  output wire [15:0] o_cpu_rdata, // read data
  output wire o_cpu_ack, // access done pulse
  input wire i_rx_valid, // received frame valid
  output wire o_rx_ready, // frame FIFO not full
  input wire [`CMBX_ID_MSB:0] i_rx_id, // frame identifier
  input wire i_rx_rtr, // remote frame
  input wire [`CMBX_DLC_MSB:0] i_rx_dlc, // data length code
  input wire [63:0] i_rx_data, // payload, byte 0 in top bits
  input wire [NUM_MBX-1:0] i_mbx_enable, // mailbox enabled
  input wire [NUM_MBX-1:0] i_mbx_is_rx, // 1 receive, 0 transmit
  input wire [`CMBX_ID_MSB:0] i_accept_mask, // 1 = don't care bit
  input wire i_defect_mode, // 1 reproduce collision copy
  output wire o_rx_done, // frame stored pulse
  output wire [MW-1:0] o_rx_mbx, // mailbox that took it
  output wire o_reply_req, // auto-answer request pulse
  output wire [MW-1:0] o_reply_mbx // mailbox to transmit
);
  localparam ST_IDLE = 3'h0; // wait for frame
  localparam ST_MATCH = 3'h1; // pick mailbox
  localparam ST_WR_ID = 3'h2; // first write: identifier word
  localparam ST_WR_CTRL = 3'h3; // control word
  localparam ST_WR_DATA = 3'h4; // payload words
  localparam ST_DONE = 3'h5; // report
  localparam NWORDS = NUM_MBX * 8; // mailbox RAM depth

  // reset synchroniser
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // frame queue between protocol engine and write engine
  wire fifo_valid;
  wire fifo_pop;
  wire [`CMBX_FRM_W-1:0] fifo_data;
  cmbx_fifo #(
    .W(`CMBX_FRM_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_valid(i_rx_valid),
    .o_ready(o_rx_ready),
    .i_data({i_rx_data, i_rx_dlc, i_rx_rtr, i_rx_id}),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_data)
  );

  reg [15:0] mem_reg [0:NWORDS-1]; // mailbox RAM
  reg [2:0] state_reg; // engine state
  reg [`CMBX_ID_MSB:0] frm_id_reg; // latched frame
  reg frm_rtr_reg;
  reg [`CMBX_DLC_MSB:0] frm_dlc_reg;
  reg [63:0] frm_data_reg;
  reg [MW-1:0] tgt_reg; // chosen mailbox
  reg answer_reg; // target is an auto-answer mailbox
  reg [1:0] dcnt_reg; // payload word counter
  reg prev_acc_reg; // processor touched RAM last cycle
  reg [1:0] prev_bits_reg; // bits 14:13 of that word
  reg [15:0] rdata_reg; // read data out
  reg ack_reg; // access ack out
  reg done_reg; // stored pulse out
  reg [MW-1:0] done_mbx_reg;
  reg reply_reg; // reply pulse out
  reg [MW-1:0] reply_mbx_reg;

  assign fifo_pop = (state_reg == ST_IDLE);
  assign o_cpu_rdata = rdata_reg;
  assign o_cpu_ack = ack_reg;
  assign o_rx_done = done_reg;
  assign o_rx_mbx = done_mbx_reg;
  assign o_reply_req = reply_reg;
  assign o_reply_mbx = reply_mbx_reg;

  // lowest-numbered set bit wins; bit MW of the result flags a hit
  function [MW:0] cmbx_first;
    input [NUM_MBX-1:0] vec;
    integer k;
    begin
      cmbx_first = {(MW+1){1'b0}};
      for (k = NUM_MBX - 1; k >= 0; k = k - 1) begin
        if (vec[k]) begin
          cmbx_first = {1'b1, k[MW-1:0]};
        end
      end
    end
  endfunction

  // acceptance test of the latched frame against every mailbox
  reg [NUM_MBX-1:0] rx_hit;
  reg [NUM_MBX-1:0] ans_hit;
  reg [15:0] idw;
  reg exact;
  reg masked;
  integer m;
  always @* begin
    rx_hit = {NUM_MBX{1'b0}};
    ans_hit = {NUM_MBX{1'b0}};
    idw = `CMBX_WORD_RST;
    exact = 1'b0;
    masked = 1'b0;
    for (m = 0; m < NUM_MBX; m = m + 1) begin
      idw = mem_reg[m * 8];
      exact = (idw[`CMBX_ID_MSB:0] == frm_id_reg);
      masked = (((idw[`CMBX_ID_MSB:0] ^ frm_id_reg) & ~i_accept_mask) == {`CMBX_ID_W{1'b0}});
      // mask filtering only while mask-enable is set, else exact only
      rx_hit[m] = i_mbx_enable[m] & i_mbx_is_rx[m] &
                  (idw[`CMBX_AME_BIT] ? masked : exact); // R04
      // transmit mailbox answers a remote request only with auto-answer set
      ans_hit[m] = i_mbx_enable[m] & ~i_mbx_is_rx[m] & frm_rtr_reg &
                   idw[`CMBX_AAM_BIT] & exact; // R05
    end
  end

  wire [MW:0] rx_pick = cmbx_first(rx_hit);
  wire [MW:0] ans_pick = cmbx_first(ans_hit);

  // engine write port, combinational from state
  reg eng_we;
  reg [AW-1:0] eng_addr;
  reg [15:0] eng_wdata;
  reg [15:0] old_id;
  reg [1:0] ctl_bits;
  always @* begin
    eng_we = 1'b0;
    eng_addr = {tgt_reg, `CMBX_W_IDENT};
    eng_wdata = `CMBX_WORD_RST;
    old_id = mem_reg[{tgt_reg, `CMBX_W_IDENT}];
    ctl_bits = old_id[`CMBX_CTL_HI:`CMBX_CTL_LO]; // R07
    // legacy path: word touched in the cycle before takes over the bits
    if (i_defect_mode && prev_acc_reg) begin
      ctl_bits = prev_bits_reg; // R02
    end
    case (state_reg)
      ST_WR_ID: begin
        // only reached by receive or auto-answer mailboxes, so only they corrupt
        eng_we = 1'b1; // R03
        eng_wdata = {old_id[15], ctl_bits, old_id[12:11], frm_id_reg}; // R01
      end
      ST_WR_CTRL: begin
        eng_we = 1'b1;
        eng_addr = {tgt_reg, `CMBX_W_CTRL};
        eng_wdata = {`CMBX_CTRL_PAD, frm_rtr_reg, frm_dlc_reg};
      end
      ST_WR_DATA: begin
        eng_we = 1'b1;
        eng_addr = {tgt_reg, `CMBX_W_DATA0 + {1'b0, dcnt_reg}};
        eng_wdata = frm_data_reg[63 - 16 * dcnt_reg -: 16];
      end
      default: begin
        eng_we = 1'b0;
      end
    endcase
  end

  // mailbox RAM; engine wins when both hit one word in one cycle
  integer r;
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (r = 0; r < NWORDS; r = r + 1) begin
        mem_reg[r] <= `CMBX_WORD_RST;
      end
    end else begin
      if (i_cpu_req && i_cpu_we && !(eng_we && eng_addr == i_cpu_addr)) begin
        mem_reg[i_cpu_addr] <= i_cpu_wdata; // R06
      end
      if (eng_we) begin
        mem_reg[eng_addr] <= eng_wdata;
      end
    end
  end

  // processor port and the one-cycle memory of its last access
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `CMBX_WORD_RST;
      ack_reg <= 1'b0;
      prev_acc_reg <= 1'b0;
      prev_bits_reg <= `CMBX_BITS2_RST;
    end else begin
      ack_reg <= i_cpu_req;
      if (i_cpu_req && !i_cpu_we) begin
        rdata_reg <= mem_reg[i_cpu_addr];
      end
      prev_acc_reg <= i_cpu_req;
      // write uses the written bits, read the stored bits
      prev_bits_reg <= i_cpu_we ? i_cpu_wdata[`CMBX_CTL_HI:`CMBX_CTL_LO]
                                : mem_reg[i_cpu_addr][`CMBX_CTL_HI:`CMBX_CTL_LO]; // R02
    end
  end

  // receive-write sequencer
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      frm_id_reg <= {`CMBX_ID_W{1'b0}};
      frm_rtr_reg <= 1'b0;
      frm_dlc_reg <= {(`CMBX_DLC_MSB+1){1'b0}};
      frm_data_reg <= 64'h0000000000000000;
      tgt_reg <= {MW{1'b0}};
      answer_reg <= 1'b0;
      dcnt_reg <= 2'h0;
      done_reg <= 1'b0;
      done_mbx_reg <= {MW{1'b0}};
      reply_reg <= 1'b0;
      reply_mbx_reg <= {MW{1'b0}};
    end else begin
      done_reg <= 1'b0;
      reply_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (fifo_valid) begin
            frm_id_reg <= fifo_data[`CMBX_FRM_ID_LO +: `CMBX_ID_W];
            frm_rtr_reg <= fifo_data[`CMBX_FRM_RTR];
            frm_dlc_reg <= fifo_data[`CMBX_FRM_DLC_LO +: 4];
            frm_data_reg <= fifo_data[`CMBX_FRM_DATA_LO +: 64];
            state_reg <= ST_MATCH;
          end
        end
        ST_MATCH: begin
          // receive mailboxes take priority; no hit drops the frame
          if (rx_pick[MW]) begin
            tgt_reg <= rx_pick[MW-1:0];
            answer_reg <= 1'b0;
            state_reg <= ST_WR_ID;
          end else if (ans_pick[MW]) begin
            tgt_reg <= ans_pick[MW-1:0];
            answer_reg <= 1'b1;
            state_reg <= ST_WR_ID;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WR_ID: begin
          // auto-answer mailbox keeps its own control and payload
          state_reg <= answer_reg ? ST_DONE : ST_WR_CTRL;
        end
        ST_WR_CTRL: begin
          dcnt_reg <= 2'h0;
          state_reg <= frm_rtr_reg ? ST_DONE : ST_WR_DATA;
        end
        ST_WR_DATA: begin
          dcnt_reg <= dcnt_reg + 1'b1;
          if (dcnt_reg == `CMBX_DATA_WORDS) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          done_reg <= 1'b1;
          done_mbx_reg <= tgt_reg;
          reply_reg <= answer_reg; // R05
          reply_mbx_reg <= tgt_reg;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== dv/cmbx_mailbox_properties.sv
/*
  Checker for the mailbox receive-write block: access answers, store and
  reply pulses.
  Assumes a bind onto cmbx_mailbox and a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cmbx_mailbox_properties #(
  parameter NUM_MBX = 6,
  parameter MW = 3
) (
  input wire logic i_mclk, // system clock
  input wire logic i_nrst, // reset, active low
  input wire logic i_cpu_req, // access strobe
  input wire logic i_cpu_we, // write select
  input wire logic [15:0] o_cpu_rdata, // read data
  input wire logic o_cpu_ack, // access done
  input wire logic [NUM_MBX-1:0] i_mbx_enable, // mailbox enables
  input wire logic [NUM_MBX-1:0] i_mbx_is_rx, // mailbox directions
  input wire logic o_rx_done, // frame stored
  input wire logic [MW-1:0] o_rx_mbx, // storing mailbox
  input wire logic o_reply_req, // reply request
  input wire logic [MW-1:0] o_reply_mbx // replying mailbox
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // every access is answered exactly one cycle later
  AST_ACK_NEXT: assert property (i_cpu_req |=> o_cpu_ack)
    else $error("access not acknowledged");
  AST_NO_STRAY_ACK: assert property (!i_cpu_req |=> !o_cpu_ack)
    else $error("ack without access");
  // read data must not move on writes or idle cycles
  AST_RDATA_HOLD: assert property (!(i_cpu_req && !i_cpu_we) |=> $stable(o_cpu_rdata))
    else $error("read data moved without read");
  // a reply always comes with the store into the same mailbox
  AST_REPLY_PAIR: assert property (o_reply_req |-> o_rx_done && o_reply_mbx == o_rx_mbx)
    else $error("reply not paired with store");
  AST_REPLY_TX: assert property (o_reply_req |-> i_mbx_enable[o_reply_mbx] && !i_mbx_is_rx[o_reply_mbx])
    else $error("reply from a non transmit mailbox");
  AST_RX_NO_REPLY: assert property (o_rx_done && i_mbx_is_rx[o_rx_mbx] |-> !o_reply_req)
    else $error("receive mailbox asked to reply");
  AST_DONE_ENABLED: assert property (o_rx_done |-> o_rx_mbx < NUM_MBX && i_mbx_enable[o_rx_mbx])
    else $error("store into disabled mailbox");
  // a store takes several cycles, so pulses never touch
  AST_DONE_PULSE: assert property (o_rx_done |=> !o_rx_done [*2])
    else $error("store pulses too close");
  COV_STORE: cover property (o_rx_done);
  COV_REPLY: cover property (o_reply_req);
  COV_ACK_STORE: cover property (o_cpu_ack && o_rx_done);
endmodule
`default_nettype wire

// ===== dv/cmbx_can_node.sv
/*
  Model of the other bus nodes: offers received frames one beat each.
  Assumes the block takes a frame on an edge with valid and ready high.
*/
`timescale 1ns/1ps
`default_nettype none
module cmbx_can_node (
  input wire logic i_mclk, // system clock
  input wire logic i_ready, // room in the frame queue
  output logic o_valid, // frame offered
  output logic [10:0] o_id, // identifier
  output logic o_rtr, // remote frame
  output logic [3:0] o_dlc, // length code
  output logic [63:0] o_data // payload
);
  integer stalls; // refused cycles seen
  integer timeouts; // offers never taken within the bound
  initial begin
    o_valid = 1'b0;
    o_id = 11'h000;
    o_rtr = 1'b0;
    o_dlc = 4'h0;
    o_data = 64'h0;
    stalls = 0;
    timeouts = 0;
  end
  // offer one frame, hold it until taken; valid stays up for the next
  task send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
            input logic [63:0] d);
    logic ok;
    int n;
    begin
      o_valid = 1'b1;
      o_id = id;
      o_rtr = rtr;
      o_dlc = dlc;
      o_data = d;
      ok = 1'b0;
      for (n = 0; n < 300 && !ok; n++) begin
        ok = i_ready;
        if (!ok) stalls = stalls + 1;
        @(posedge i_mclk);
        #1;
      end
      // a frame never taken is reported through the bench
      if (!ok) timeouts = timeouts + 1;
    end
  endtask
  // released lines must not keep a stale frame
  task release_bus;
    begin
      o_valid = 1'b0;
      o_id = ~o_id;
      o_rtr = ~o_rtr;
      o_dlc = ~o_dlc;
      o_data = ~o_data;
    end
  endtask
endmodule
`default_nettype wire

// ===== dv/cmbx_mailbox_tb.sv
/*
  Testbench of the mailbox receive-write block: storing, collision copy,
  corrected write, auto-answer and frame queue fill.
  Assumes the node model and the bound checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module cmbx_mailbox_tb;
  localparam NUM_MBX = 6;
  localparam MW = 3;
  logic i_mclk = 1'b0, i_nrst = 1'b0, i_cpu_req, i_cpu_we, i_defect_mode;
  logic o_cpu_ack, rx_valid, o_rx_ready, rx_rtr, o_rx_done, o_reply_req;
  logic [5:0] i_cpu_addr, i_mbx_enable, i_mbx_is_rx;
  logic [15:0] i_cpu_wdata, o_cpu_rdata;
  logic [10:0] rx_id, i_accept_mask;
  logic [3:0] rx_dlc;
  logic [63:0] rx_data;
  logic [2:0] o_rx_mbx, o_reply_mbx;
  integer miscompares = 0, checks_done = 0;
  always #2.5 i_mclk = ~i_mclk;
  cmbx_mailbox dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cpu_req(i_cpu_req),
    .i_cpu_we(i_cpu_we), .i_cpu_addr(i_cpu_addr), .i_cpu_wdata(i_cpu_wdata),
    .o_cpu_rdata(o_cpu_rdata), .o_cpu_ack(o_cpu_ack), .i_rx_valid(rx_valid),
    .o_rx_ready(o_rx_ready), .i_rx_id(rx_id), .i_rx_rtr(rx_rtr), .i_rx_dlc(rx_dlc),
    .i_rx_data(rx_data), .i_mbx_enable(i_mbx_enable), .i_mbx_is_rx(i_mbx_is_rx),
    .i_accept_mask(i_accept_mask), .i_defect_mode(i_defect_mode), .o_rx_done(o_rx_done),
    .o_rx_mbx(o_rx_mbx), .o_reply_req(o_reply_req), .o_reply_mbx(o_reply_mbx));
  cmbx_can_node node (.i_mclk(i_mclk), .i_ready(o_rx_ready), .o_valid(rx_valid),
    .o_id(rx_id), .o_rtr(rx_rtr), .o_dlc(rx_dlc), .o_data(rx_data));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      if (miscompares == 0 && checks_done > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  // one access held for n edges; n > 1 gives back-to-back accesses
  task cpu(input logic we, input logic [5:0] a, input logic [15:0] d, input int n);
    begin
      i_cpu_req = 1'b1;
      i_cpu_we = we;
      i_cpu_addr = a;
      i_cpu_wdata = d;
      repeat (n) @(posedge i_mclk);
      #1;
      i_cpu_req = 1'b0;
      check({15'h0000, o_cpu_ack}, 16'h0001);
      // one idle edge, so a following access never re-raises req in this step
      @(posedge i_mclk);
      #1;
    end
  endtask
  task rd(input logic [5:0] a, input logic [15:0] exp);
    begin
      cpu(1'b0, a, 16'h0000, 1);
      check(o_cpu_rdata, exp);
    end
  endtask
  task frame(input logic [10:0] id, input logic rtr);
    begin
      node.send(id, rtr, 4'h8, 64'h1122_3344_5566_7788);
      node.release_bus;
    end
  endtask
  // bounded wait for a store pulse; a missing one ends the run
  task expect_store(input logic hit, input logic [2:0] mbx, input logic reply);
    logic seen;
    int k;
    begin
      seen = 1'b0;
      for (k = 0; k < 100 && !seen; k++) begin
        @(posedge i_mclk);
        #1;
        seen = o_rx_done;
      end
      check({15'h0000, seen}, {15'h0000, hit});
      if (hit && seen) begin
        check({13'h0000, o_rx_mbx}, {13'h0000, mbx});
        check({15'h0000, o_reply_req}, {15'h0000, reply});
        if (reply) check({13'h0000, o_reply_mbx}, {13'h0000, mbx});
      end
      if (hit && !seen) summarize;
    end
  endtask
  // frame lands while the processor hammers a word for six cycles;
  // the store is watched in parallel, a reply pulse ends on the edge of the last access
  task collide(input logic mode, input logic we, input logic [5:0] a,
               input logic [10:0] id, input logic rtr, input logic [2:0] mbx);
    begin
      i_defect_mode = mode;
      fork
        frame(id, rtr);
        cpu(we, a, 16'h0000, 6);
        expect_store(1'b1, mbx, rtr);
      join
    end
  endtask
  task t_store;
    begin
      rd(6'h00, 16'h0000);
      cpu(1'b1, 6'h00, 16'h6123, 1);
      cpu(1'b1, 6'h18, 16'h4055, 1);
      frame(11'h125, 1'b0);
      expect_store(1'b1, 3'h0, 1'b0);
      rd(6'h00, 16'h6125);
      rd(6'h01, 16'h0008);
      rd(6'h02, 16'h1122);
      rd(6'h05, 16'h7788);
    end
  endtask
  task t_collide;
    begin
      collide(1'b1, 1'b1, 6'h2F, 11'h126, 1'b0, 3'h0);
      rd(6'h00, 16'h0126);
      frame(11'h127, 1'b0);
      expect_store(1'b0, 3'h0, 1'b0);
      cpu(1'b1, 6'h00, 16'h6120, 1);
      frame(11'h127, 1'b0);
      expect_store(1'b1, 3'h0, 1'b0);
      collide(1'b1, 1'b0, 6'h18, 11'h129, 1'b0, 3'h0);
      rd(6'h00, 16'h4129);
      cpu(1'b1, 6'h00, 16'h6120, 1);
      collide(1'b0, 1'b1, 6'h2F, 11'h12A, 1'b0, 3'h0);
      rd(6'h00, 16'h612A);
    end
  endtask
  // auto-answer mailbox loses its answer bit to a collision
  task t_reply;
    begin
      collide(1'b1, 1'b1, 6'h2F, 11'h055, 1'b1, 3'h3);
      rd(6'h18, 16'h0055);
      frame(11'h055, 1'b1);
      expect_store(1'b0, 3'h0, 1'b0);
    end
  endtask
  // queue fills while the engine drops frames, then drains in order
  task t_fifo;
    int k;
    begin
      for (k = 0; k < 40; k++) node.send(11'h7FF, 1'b0, 4'h8, 64'h0);
      check({15'h0000, node.stalls > 0}, 16'h0001);
      check(node.timeouts[15:0], 16'h0000);
      frame(11'h125, 1'b0);
      expect_store(1'b1, 3'h0, 1'b0);
    end
  endtask
  initial begin
    i_cpu_req = 1'b0;
    i_cpu_we = 1'b0;
    i_cpu_addr = 6'h00;
    i_cpu_wdata = 16'h0000;
    i_mbx_enable = 6'h09;
    i_mbx_is_rx = 6'h01;
    i_accept_mask = 11'h00F;
    i_defect_mode = 1'b1;
    repeat (3) @(posedge i_mclk);
    #1;
    i_nrst = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1;
    check({15'h0000, o_rx_ready}, 16'h0001);
    t_store;
    t_collide;
    t_reply;
    t_fifo;
    summarize;
  end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    summarize;
  end
endmodule
bind cmbx_mailbox cmbx_mailbox_properties #(.NUM_MBX(NUM_MBX), .MW(MW)) u_props (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_cpu_req(i_cpu_req), .i_cpu_we(i_cpu_we),
  .o_cpu_rdata(o_cpu_rdata), .o_cpu_ack(o_cpu_ack), .i_mbx_enable(i_mbx_enable),
  .i_mbx_is_rx(i_mbx_is_rx), .o_rx_done(o_rx_done), .o_rx_mbx(o_rx_mbx),
  .o_reply_req(o_reply_req), .o_reply_mbx(o_reply_mbx));
`default_nettype wire
